// ==== bench/host_model.sv ====
// Host model that issues queued read commands
`timescale 1ns/1ps
module host_model (
   input wire clk_sys,
   output reg cmd_valid = 1'b0,
   output reg [47:0] a = 48'h0,
   output reg [7:0] pb = 8'h00,
   output reg [7:0] cd = 8'h00,
   output reg [7:0] dh = 8'h00,
   output reg [7:0] tg = 8'h00
);
   task issue(input [47:0] x, input [1:0] p, input [7:0] c, input f);
      @(posedge clk_sys);
      cmd_valid <= 1'b1;
      a <= x;
      pb <= {p, 6'h00};
      cd <= c;
      dh <= {f, 7'h00};
      tg <= tg + 8'h08;
      @(posedge clk_sys);
      cmd_valid <= 1'b0;
   endtask
endmodule // host_model

// ==== bench/qrd_assertions.sv ====
// Checker for the queued read field decoder
`timescale 1ns/1ps
module qrd_assertions (
   input wire clk_sys,
   input wire rst_n,
   input wire cmd_valid,
   input wire abort_on_expiry,
   input wire [7:0] sector_count_prev,
   input wire [7:0] deadline_code_slot,
   input wire [7:0] device_head,
   input wire force_media_access,
   input wire cache_allowed,
   input wire [6:0] deadline_limit_m1,
   input wire cmd_abort,
   input wire cmd_busy
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   wire take = cmd_valid && !cmd_busy;
   wire iso = sector_count_prev[7:6] == 2'h1;
   wire [6:0] lim = deadline_code_slot[6:0];
   a_take_busy: assert property (take |=> cmd_busy) else $error("no busy");
   a_code_used: assert property (take && iso |=> deadline_limit_m1 == $past(lim))
      else $error("limit");
   a_code_ignore: assert property (take && !iso |=> !deadline_limit_m1)
      else $error("limit kept");
   a_media_take: assert property (take |=> force_media_access == $past(device_head[7]))
      else $error("media");
   a_cache_gate: assert property (cache_allowed != force_media_access) else $error("cache");
   a_abort_gate: assert property (cmd_abort |-> $past(abort_on_expiry) && !cmd_busy)
      else $error("abort");
   a_abort_pulse: assert property (cmd_abort |=> !cmd_abort) else $error("abort long");
   a_refuse_hold: assert property (cmd_valid && cmd_busy |=> $stable(deadline_limit_m1))
      else $error("refused");
   c_take: cover property (take && iso);
   c_abort: cover property (cmd_abort);
   c_refuse: cover property (cmd_valid && cmd_busy);
endmodule // qrd_assertions
bind queued_read_field_decode qrd_assertions u_chk (
   .clk_sys(clk_sys),
   .rst_n(rst_n),
   .cmd_valid(cmd_valid),
   .abort_on_expiry(abort_on_expiry),
   .sector_count_prev(sector_count_prev),
   .deadline_code_slot(deadline_code_slot),
   .device_head(device_head),
   .force_media_access(force_media_access),
   .cache_allowed(cache_allowed),
   .deadline_limit_m1(deadline_limit_m1),
   .cmd_abort(cmd_abort),
   .cmd_busy(cmd_busy)
);

// ==== bench/tb.sv ====
// Bench for the queued read field decoder
`timescale 1ns/1ps
module tb;
   reg clk_sys = 1'b0;
   reg rst_n = 1'b0;
   reg cmd_done = 1'b0;
   reg abort_on_expiry = 1'b0;
   wire cmd_valid, is_high, is_isoch, force_media_access, cache_allowed, deadline_active;
   wire deadline_coarse, deadline_expired, cmd_abort, cmd_busy;
   wire [47:0] lba, a;
   wire [7:0] pb, cd, dh, tg;
   wire [6:0] deadline_limit_m1;
   wire [4:0] tag;
   wire [1:0] priority_class;
   integer errors = 0, check_count = 0, n, p;
   host_model u_host (
      .clk_sys(clk_sys),
      .cmd_valid(cmd_valid),
      .a(a),
      .pb(pb),
      .cd(cd),
      .dh(dh),
      .tg(tg)
   );
   queued_read_field_decode #(.FINE_CYC(10), .COARSE_CYC(50)) u_dut (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .cmd_valid(cmd_valid),
      .sector_num_cur(a[7:0]),
      .sector_num_prev(a[31:24]),
      .cyl_low_cur(a[15:8]),
      .cyl_low_prev(a[39:32]),
      .cyl_high_cur(a[23:16]),
      .cyl_high_prev(a[47:40]),
      .sector_count_cur(tg),
      .sector_count_prev(pb),
      .deadline_code_slot(cd),
      .device_head(dh),
      .abort_on_expiry(abort_on_expiry),
      .cmd_done(cmd_done),
      .lba(lba),
      .tag(tag),
      .priority_class(priority_class),
      .is_high(is_high),
      .is_isoch(is_isoch),
      .force_media_access(force_media_access),
      .cache_allowed(cache_allowed),
      .deadline_active(deadline_active),
      .deadline_coarse(deadline_coarse),
      .deadline_limit_m1(deadline_limit_m1),
      .deadline_expired(deadline_expired),
      .cmd_abort(cmd_abort),
      .cmd_busy(cmd_busy)
   );
   initial forever #5 clk_sys = ~clk_sys;
   task check(input [47:0] nm, input [47:0] s, input [47:0] e);
      check_count = check_count + 1;
      if (s !== e)
      begin
         errors = errors + 1;
         $display("Error %0s exp %h got %h", nm, e, s);
      end
   endtask
   task finish_test;
      if (errors == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task wait_for(input sel);
      n = 0;
      #1;
      while ((sel ? cmd_abort : deadline_expired) !== 1'b1 && n < 200)
      begin
         @(posedge clk_sys);
         #1;
         n = n + 1;
      end
      check("wait", n < 200, 1'b1);
   endtask
   task done;
      @(posedge clk_sys);
      cmd_done <= 1'b1;
      @(posedge clk_sys);
      cmd_done <= 1'b0;
      #1;
      check("idle", cmd_busy, 1'b0);
   endtask
   initial
   begin
      repeat (2) @(posedge clk_sys);
      rst_n <= 1'b1;
      // Each command is followed by one that must be refused
      for (p = 0; p < 4; p = p + 1)
      begin
         u_host.issue(48'ha1b2c3d4e5f6 + p, p[1:0], 8'h85 + p[7:0], p[0]);
         u_host.issue(48'h0, 2'h1, 8'h00, !p[0]);
         #1;
         check("lba", lba, 48'ha1b2c3d4e5f6 + p);
         check("iso", is_isoch, p == 1);
         check("high", is_high, p == 2);
         check("limit", deadline_limit_m1, p == 1 ? 6 : 0);
         check("media", force_media_access, p[0]);
         check("cache", cache_allowed, !p[0]);
         check("tag", tag, 2 * p + 1);
         check("class", priority_class, p[1:0]);
         check("coarse", deadline_coarse, p == 1);
         check("active", deadline_active, p == 1);
         done;
      end
      u_host.issue(48'h1, 2'h1, 8'h02, 1'b0);
      wait_for(0);
      check("fine", n > 27 && n < 33, 1'b1);
      check("keep", cmd_busy, 1'b1);
      check("active", deadline_active, 1'b0);
      check("late", deadline_expired, 1'b1);
      done;
      @(posedge clk_sys);
      abort_on_expiry <= 1'b1;
      u_host.issue(48'h2, 2'h1, 8'h81, 1'b1);
      wait_for(1);
      check("coarse", n > 97 && n < 103, 1'b1);
      check("abort", cmd_busy, 1'b0);
      check("late", deadline_expired, 1'b1);
      finish_test;
   end
endmodule // tb

// ==== design/deadline_timer.v ====
// Deadline timer: counts interval ticks up to the decoded time limit
`timescale 1ns/1ps
`include "qrd_map.vh"
module deadline_timer #(
   parameter FINE_CYC = `FINE_UNIT_CYC,
   parameter COARSE_CYC = `COARSE_UNIT_CYC
)(
   input wire clk_sys,
   input wire rst_n,
   input wire start,
   input wire stop,
   input wire coarse,
   input wire [6:0] limit_m1,
   output reg running,
   output reg expired
);
   reg [25:0] div;
   reg [7:0] ticks;
   reg [7:0] limit;
   reg is_coarse;
   wire [25:0] unit_m1 = is_coarse ? COARSE_CYC[25:0] - 26'h1 : FINE_CYC[25:0] - 26'h1;
   wire tick = running && (div == unit_m1);
   // ==========================================
   // Interval divider and limit counter
   always @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         running <= 1'b0;
         expired <= 1'b0;
         div <= 26'h0;
         ticks <= 8'h0;
         limit <= 8'h0;
         is_coarse <= 1'b0;
      end
      else if (start)
      begin
         running <= 1'b1;
         expired <= 1'b0;
         div <= 26'h0;
         ticks <= 8'h0;
         limit <= {1'b0, limit_m1} + 8'h1; // see R5 see R6
         is_coarse <= coarse;
      end
      else if (stop)
      begin
         running <= 1'b0;
         expired <= 1'b0;
         div <= 26'h0;
         ticks <= 8'h0;
      end
      else if (running)
      begin
         div <= tick ? 26'h0 : div + 26'h1;
         if (tick)
         begin
            ticks <= ticks + 8'h1;
            if (ticks + 8'h1 == limit)
            begin
               running <= 1'b0;
               expired <= 1'b1;
            end
         end
      end
   end
endmodule // deadline_timer

// ==== design/qrd_map.vh ====
// Field positions, encodings and timing counts for the queued read field decoder
`ifndef QRD_MAP_VH
`define QRD_MAP_VH
`define PCLASS_NORMAL 2'h0
`define PCLASS_ISOCH 2'h1
`define PCLASS_HIGH 2'h2
`define PCLASS_LSB 6
`define TAG_LSB 3
`define FMA_BIT 7
`define DL_COARSE_BIT 7
`define CLK_NS 10
`define FINE_UNIT_MS 10
`define COARSE_UNIT_MS 500
`define FINE_UNIT_CYC (`FINE_UNIT_MS * 1000000 / `CLK_NS)
`define COARSE_UNIT_CYC (`COARSE_UNIT_MS * 1000000 / `CLK_NS)
`endif

// ==== design/queued_read_field_decode.v ====
// Decoder for queued read command fields: address, priority, deadline, media access
// Contract
// R1: Deadline code only used when priority class is 01b.
// R2: Host fills deadline code per intended completion deadline.
// R3: By default an expired command keeps running and completes quickly.
// R4: Host may select abort of expired commands if supported.
// R5: Top bit zero: limit is (low seven bits plus one) times 10 ms.
// R6: Top bit one: limit is (low seven bits plus one) times 0.5 s.
// R7: Force-media-access one: always read from media, bypass buffer.
// R8: Force-media-access zero: cache or media may supply data.
// R9: Cylinder fields carry address bits 15:8, 23:16, 39:32, 47:40.
// R10: Priority 00b normal, 01b isochronous, 10b high; meet isochronous deadlines.
// R11: Host gives unique tags in bits 7 to 3 within queue depth.
`timescale 1ns/1ps
`include "qrd_map.vh"
module queued_read_field_decode #(
   parameter FINE_CYC = `FINE_UNIT_CYC,
   parameter COARSE_CYC = `COARSE_UNIT_CYC
)(
   input wire clk_sys,
   input wire rst_n,
   input wire cmd_valid,
   input wire [7:0] sector_num_cur,
   input wire [7:0] sector_num_prev,
   input wire [7:0] cyl_low_cur,
   input wire [7:0] cyl_low_prev,
   input wire [7:0] cyl_high_cur,
   input wire [7:0] cyl_high_prev,
   input wire [7:0] sector_count_cur,
   input wire [7:0] sector_count_prev,
   input wire [7:0] deadline_code_slot,
   input wire [7:0] device_head,
   input wire abort_on_expiry,
   input wire cmd_done,
   output reg [47:0] lba,
   output reg [4:0] tag,
   output reg [1:0] priority_class,
   output reg is_high,
   output reg is_isoch,
   output reg force_media_access,
   output reg cache_allowed,
   output reg deadline_active,
   output reg deadline_coarse,
   output reg [6:0] deadline_limit_m1,
   output reg deadline_expired,
   output reg cmd_abort,
   output reg cmd_busy
);
   localparam ST_IDLE = 2'h0;
   localparam ST_RUN = 2'h1;
   localparam ST_LATE = 2'h2;
   reg [1:0] state;
   reg next_coarse;
   reg [6:0] next_limit_m1;
   reg next_fma;
   wire [1:0] pclass_in = sector_count_prev[`PCLASS_LSB+1:`PCLASS_LSB];
   wire [4:0] tag_in = sector_count_cur[7:`TAG_LSB];
   wire [1:0] flags_in;
   wire isoch_in;
   wire high_in;
   wire [7:0] addr_byte [0:5];
   wire [47:0] lba_in;
   wire tmr_expired;
   wire take = cmd_valid && (state == ST_IDLE);
   genvar gi;
   // ==========================================
   // Priority class decode, bit 0 isochronous, bit 1 high
   function [1:0] class_flags;
      input [1:0] pclass;
      begin
         // Reserved class 11b falls to normal handling
         case (pclass)
            `PCLASS_ISOCH: class_flags = 2'h1;
            `PCLASS_HIGH: class_flags = 2'h2;
            default: class_flags = 2'h0;
         endcase
      end
   endfunction
   assign flags_in = class_flags(pclass_in); // see R10
   assign isoch_in = flags_in[0]; // see R1 see R10
   assign high_in = flags_in[1];
   // ==========================================
   // Address assembly from the six address fields
   assign addr_byte[0] = sector_num_cur;
   assign addr_byte[1] = cyl_low_cur;
   assign addr_byte[2] = cyl_high_cur;
   assign addr_byte[3] = sector_num_prev;
   assign addr_byte[4] = cyl_low_prev;
   assign addr_byte[5] = cyl_high_prev;
   generate
      for (gi = 0; gi < 6; gi = gi + 1)
      begin : g_addr
         assign lba_in[gi*8+7:gi*8] = addr_byte[gi]; // see R9
      end
   endgenerate
   // ==========================================
   // Deadline fields of the offered command, cleared unless isochronous
   always @*
   begin
      next_coarse = 1'b0;
      next_limit_m1 = 7'h0;
      next_fma = device_head[`FMA_BIT]; // see R7
      if (isoch_in) // see R1
      begin
         next_coarse = deadline_code_slot[`DL_COARSE_BIT]; // see R5 see R6
         next_limit_m1 = deadline_code_slot[6:0];
      end
   end
   // ==========================================
   // Deadline timer, started for isochronous commands only
   deadline_timer #(
      .FINE_CYC(FINE_CYC),
      .COARSE_CYC(COARSE_CYC)
   ) u_timer (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .start(take && isoch_in), // see R1
      .stop(cmd_done || cmd_abort),
      .coarse(next_coarse), // see R5 see R6
      .limit_m1(next_limit_m1),
      .running(),
      .expired(tmr_expired)
   );
   // ==========================================
   // Field capture on command acceptance
   always @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         lba <= 48'h0;
         tag <= 5'h0;
         priority_class <= `PCLASS_NORMAL;
         is_high <= 1'b0;
         is_isoch <= 1'b0;
         force_media_access <= 1'b0;
         cache_allowed <= 1'b1;
         deadline_coarse <= 1'b0;
         deadline_limit_m1 <= 7'h0;
      end
      else if (take)
      begin
         lba <= lba_in; // see R9
         tag <= tag_in;
         priority_class <= pclass_in; // see R10
         is_high <= high_in;
         is_isoch <= isoch_in;
         force_media_access <= next_fma; // see R7
         cache_allowed <= ~next_fma; // see R8
         deadline_coarse <= next_coarse;
         deadline_limit_m1 <= next_limit_m1; // see R1
      end
   end
   // ==========================================
   // Command lifetime and expiry handling
   always @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         state <= ST_IDLE;
         cmd_busy <= 1'b0;
         cmd_abort <= 1'b0;
         deadline_active <= 1'b0;
         deadline_expired <= 1'b0;
      end
      else
      begin
         cmd_abort <= 1'b0;
         case (state)
            ST_IDLE:
            begin
               // Fields and timer start on the same edge
               if (take)
               begin
                  state <= ST_RUN;
                  cmd_busy <= 1'b1;
                  deadline_active <= isoch_in;
                  deadline_expired <= 1'b0;
               end
            end
            ST_RUN:
            begin
               // Completion wins over a same-cycle expiry
               if (cmd_done)
               begin
                  state <= ST_IDLE;
                  cmd_busy <= 1'b0;
                  deadline_active <= 1'b0;
               end
               else if (tmr_expired)
               begin
                  deadline_active <= 1'b0;
                  deadline_expired <= 1'b1;
                  // Abort only when the host selected it
                  if (abort_on_expiry) // see R4
                  begin
                     state <= ST_IDLE;
                     cmd_busy <= 1'b0;
                     cmd_abort <= 1'b1;
                  end
                  else
                  begin
                     state <= ST_LATE; // see R3
                  end
               end
            end
            ST_LATE:
            begin
               // Late command still runs to completion
               if (cmd_done) // see R3
               begin
                  state <= ST_IDLE;
                  cmd_busy <= 1'b0;
               end
            end
            default:
            begin
               // Unused code recovers to idle
               state <= ST_IDLE;
            end
         endcase
      end
   end
endmodule // queued_read_field_decode
